// ===== logic/can_fc_pkg.sv
// shared constants and types for the can error confinement block
package can_fc_pkg;
  // bus levels
  localparam logic LVL_DOM = 1'b0;
  localparam logic LVL_REC = 1'b1;
  // counter widths
  localparam int REC_W = 7;
  localparam int TEC_W = 8;
  // state thresholds and counter steps
  localparam logic [7:0] PASSIVE_LIMIT = 8'h7f;
  localparam logic [3:0] STUFF_RUN = 4'h6;
  localparam logic [3:0] FLAG_BITS = 4'h6;
  localparam logic [3:0] DELIM_BITS = 4'h8;
  localparam logic [4:0] ACTIVE_DOM_RUN = 5'h0e;
  localparam logic [4:0] PASSIVE_DOM_RUN = 5'h08;
  localparam logic [4:0] EXTRA_DOM_RUN = 5'h08;
  localparam logic [3:0] IDLE_RUN = 4'hb;
  localparam logic [7:0] RECOVER_COUNT = 8'h80;
  localparam logic MODE_STANDARD = 1'b0;
  localparam logic MODE_ENHANCED = 1'b1;

  // fault confinement state
  typedef enum logic [2:0] {
    ERR_ACTIVE = 3'b001,
    ERR_PASSIVE = 3'b010,
    ERR_BUS_OFF = 3'b100
  } fc_state_t;

  // error frame sequencing
  typedef enum logic [3:0] {
    FL_IDLE = 4'b0001,
    FL_FLAG = 4'b0010,
    FL_AFTER = 4'b0100,
    FL_DELIM = 4'b1000
  } flag_phase_t;

  // per-bit context from the protocol engine, valid with bit_sample
  typedef struct packed {
    logic bit_sample;
    logic transmitting;
    logic tx_bit;
    logic stuff_field;
    logic arb_field;
    logic stuff_bit;
    logic ack_slot;
    logic fixed_bit;
    logic fixed_level;
    logic last_eof_bit;
    logic crc_check;
    logic crc_nonzero;
    logic overload_start;
    logic rx_ok;
    logic tx_ok;
  } bit_ctx_t;

  // detected error pulses
  typedef struct packed {
    logic bit_err;
    logic stuff_err;
    logic form_err;
    logic crc_err;
    logic ack_err;
  } err_flags_t;
endpackage

// ===== logic/err_counter.sv
// saturating error counter with one overflow bit above its width
`timescale 1ns/10ps
module err_counter #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // count controls
  input wire logic add_one,
  input wire logic add_eight,
  input wire logic dec_one,
  input wire logic clear,
  // count, top bit marks overflow
  output logic [WIDTH:0] count
);
  localparam logic [WIDTH+1:0] MAX = {1'b0, {(WIDTH+1){1'b1}}};
  localparam logic [WIDTH+1:0] STEP8 = (WIDTH+2)'(8);
  localparam logic [WIDTH+1:0] STEP1 = (WIDTH+2)'(1);

  logic [WIDTH+1:0] sum;

  // increments win over a decrement in the same cycle; saturate so overflow sticks
  always_comb begin
    sum = {1'b0, count};
    if (add_eight) begin
      sum = sum + STEP8;
    end else if (add_one) begin
      sum = sum + STEP1;
    end
    if (sum > MAX) begin
      sum = MAX;
    end
  end

  // never wraps below zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (add_eight || add_one) begin
      count <= sum[WIDTH:0];
    end else if (dec_one && count != '0) begin
      count <= count - (WIDTH+1)'(1);
    end
  end
endmodule

// ===== logic/can_error_confinement.sv
// can error detection, error counters and fault confinement states
// Notes on behaviour
// - transmitter flags mismatched readback; listed exemptions apply
// - six equal stuffed bits give stuff error
// - wrong fixed bit is form error
// - receiver flags nonzero crc remainder
// - transmitter flags missing dominant acknowledge
// - active sends dominant flag, passive recessive
// - either counter above 127 means passive
// - error causing passive still sends dominant flag
// - passive returns active when both below 128
// - transmit counter above 255 means bus off
// - standard mode: 128 runs of 11 recessive
// - enhanced mode: 128 runs of 11 recessive, each after a dominant bit except the first run after entering bus off
// - recovery from bus off clears both counters
// - receive counter 7 bits, transmit 8 bits
// - receiver adds 8 for flag-time faults
// - long dominant runs after flags add 8
// - other errors: receiver +1, transmitter +8
// - valid frame decrements counter unless zero
// - transmitter adds 8 on active flag bit error
// - arbitration stuff readback error spares transmit counter
// - silent passive ack error spares transmit counter
`timescale 1ns/10ps
module can_error_confinement (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // bus pins
  input wire logic can_rx,
  output logic can_tx,
  output logic can_tx_en,
  // protocol engine side
  input wire can_fc_pkg::bit_ctx_t ctx,
  input wire logic fault_recovery_mode_select,
  // status
  output can_fc_pkg::err_flags_t err_pulse,
  output logic [can_fc_pkg::REC_W:0] receive_error_count,
  output logic [can_fc_pkg::TEC_W:0] transmit_error_count,
  output logic error_passive,
  output logic bus_off,
  output logic flag_active
);
  can_fc_pkg::fc_state_t state_reg;
  can_fc_pkg::fc_state_t state_next;
  can_fc_pkg::flag_phase_t phase_reg;
  logic rx_meta_reg;
  logic rx_reg;
  logic rx;
  logic sample;
  logic last_rx_reg;
  logic [3:0] run_reg;
  logic [3:0] flag_cnt_reg;
  logic [4:0] dom_run_reg;
  logic first_after_reg;
  logic flag_dom_reg;
  logic flag_tx_role_reg;
  logic flag_passive_reg;
  logic ack_pend_reg;
  logic dom_seen_reg;
  logic extra_mode_reg;
  logic [3:0] idle_run_reg;
  logic [7:0] recov_cnt_reg;
  logic can_tx_reg;
  can_fc_pkg::err_flags_t det;
  logic any_err;
  logic arb_stuff_spare;
  logic flag_bit_err;
  logic first_dom_err;
  logic dom_run_hit;
  logic rec_add1, rec_add8, tec_add8;
  logic recover;
  logic in_bus_off;
  logic [can_fc_pkg::REC_W:0] rec_cnt;
  logic [can_fc_pkg::TEC_W:0] tec_cnt;

  // two stages before the pin is used anywhere
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta_reg <= can_fc_pkg::LVL_REC;
      rx_reg <= can_fc_pkg::LVL_REC;
    end else begin
      rx_meta_reg <= can_rx;
      rx_reg <= rx_meta_reg;
    end
  end

  assign rx = rx_reg;
  assign in_bus_off = state_reg == can_fc_pkg::ERR_BUS_OFF;
  // bus off takes no part in the bus, so nothing is sampled for errors
  assign sample = ctx.bit_sample && !in_bus_off;

  // same-level run length inside stuffed fields
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= '0;
      last_rx_reg <= can_fc_pkg::LVL_REC;
    end else if (sample) begin
      last_rx_reg <= rx;
      if (!ctx.stuff_field || rx != last_rx_reg) begin
        run_reg <= 4'h1;
      end else if (run_reg < can_fc_pkg::STUFF_RUN) begin
        run_reg <= run_reg + 4'h1;
      end
    end
  end

  // frame error detection, only while no error frame is in progress
  always_comb begin
    det = '0;
    arb_stuff_spare = 1'b0;
    if (sample && phase_reg == can_fc_pkg::FL_IDLE) begin
      // arbitration loss and ack overwrite are legal dominant readings
      det.bit_err = ctx.transmitting && rx != ctx.tx_bit &&
                    !(rx == can_fc_pkg::LVL_DOM && (ctx.arb_field || ctx.ack_slot));
      // a recessive stuff bit read back dominant in arbitration
      arb_stuff_spare = ctx.transmitting && ctx.arb_field && ctx.stuff_bit &&
                        ctx.tx_bit == can_fc_pkg::LVL_REC && rx == can_fc_pkg::LVL_DOM;
      det.stuff_err = (ctx.stuff_field && rx == last_rx_reg &&
                       run_reg == can_fc_pkg::STUFF_RUN - 4'h1) || arb_stuff_spare;
      det.form_err = ctx.fixed_bit && rx != ctx.fixed_level &&
                     !(ctx.last_eof_bit && !ctx.transmitting && rx == can_fc_pkg::LVL_DOM);
      det.crc_err = ctx.crc_check && ctx.crc_nonzero && !ctx.transmitting;
      det.ack_err = ctx.transmitting && ctx.ack_slot && rx == can_fc_pkg::LVL_REC;
    end
  end

  assign any_err = |det;

  // registered copy of the detected errors for software and the engine
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      err_pulse <= '0;
    end else begin
      err_pulse <= det;
    end
  end

  // error and overload frame sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= can_fc_pkg::FL_IDLE;
      flag_cnt_reg <= '0;
      dom_run_reg <= '0;
      first_after_reg <= 1'b0;
      flag_dom_reg <= 1'b0;
      flag_tx_role_reg <= 1'b0;
      flag_passive_reg <= 1'b0;
      ack_pend_reg <= 1'b0;
      dom_seen_reg <= 1'b0;
      extra_mode_reg <= 1'b0;
    end else if (in_bus_off) begin
      phase_reg <= can_fc_pkg::FL_IDLE;
      ack_pend_reg <= 1'b0;
    end else if (sample) begin
      unique case (phase_reg)
        can_fc_pkg::FL_IDLE: begin
          if (any_err || ctx.overload_start) begin
            phase_reg <= can_fc_pkg::FL_FLAG;
            flag_cnt_reg <= '0;
            // old state decides the level, so the error that makes us passive still sends dominant
            flag_dom_reg <= ctx.overload_start || state_reg == can_fc_pkg::ERR_ACTIVE;
            flag_passive_reg <= !ctx.overload_start && state_reg != can_fc_pkg::ERR_ACTIVE;
            flag_tx_role_reg <= ctx.transmitting;
            ack_pend_reg <= det.ack_err && state_reg == can_fc_pkg::ERR_PASSIVE;
            dom_seen_reg <= 1'b0;
          end
        end
        can_fc_pkg::FL_FLAG: begin
          if (!flag_dom_reg && rx == can_fc_pkg::LVL_DOM) begin
            dom_seen_reg <= 1'b1;
          end
          if (flag_cnt_reg == can_fc_pkg::FLAG_BITS - 4'h1) begin
            phase_reg <= can_fc_pkg::FL_AFTER;
            dom_run_reg <= '0;
            first_after_reg <= 1'b1;
            extra_mode_reg <= 1'b0;
            ack_pend_reg <= 1'b0;
          end
          flag_cnt_reg <= flag_cnt_reg + 4'h1;
        end
        can_fc_pkg::FL_AFTER: begin
          first_after_reg <= 1'b0;
          if (rx == can_fc_pkg::LVL_REC) begin
            phase_reg <= can_fc_pkg::FL_DELIM;
            flag_cnt_reg <= 4'h1;
          end else if (dom_run_hit) begin
            dom_run_reg <= '0;
            extra_mode_reg <= 1'b1;
          end else begin
            dom_run_reg <= dom_run_reg + 5'h01;
          end
        end
        can_fc_pkg::FL_DELIM: begin
          if (flag_cnt_reg == can_fc_pkg::DELIM_BITS - 4'h1) begin
            phase_reg <= can_fc_pkg::FL_IDLE;
          end
          flag_cnt_reg <= flag_cnt_reg + 4'h1;
        end
        default: phase_reg <= can_fc_pkg::FL_IDLE;
      endcase
    end
  end

  // events on the bits around an error flag
  assign flag_bit_err = sample && phase_reg == can_fc_pkg::FL_FLAG && flag_dom_reg &&
                        rx == can_fc_pkg::LVL_REC;
  assign first_dom_err = sample && phase_reg == can_fc_pkg::FL_AFTER && first_after_reg &&
                         rx == can_fc_pkg::LVL_DOM && !flag_tx_role_reg;
  // 14th dominant after active or overload flag, 8th after passive, then every 8
  assign dom_run_hit = sample && phase_reg == can_fc_pkg::FL_AFTER && rx == can_fc_pkg::LVL_DOM &&
                       dom_run_reg + 5'h01 == (extra_mode_reg ? can_fc_pkg::EXTRA_DOM_RUN :
                       flag_passive_reg ? can_fc_pkg::PASSIVE_DOM_RUN : can_fc_pkg::ACTIVE_DOM_RUN);

  // counter steps per role
  always_comb begin
    rec_add1 = 1'b0;
    rec_add8 = 1'b0;
    tec_add8 = 1'b0;
    if (any_err && !ctx.transmitting) begin
      rec_add1 = 1'b1;
    end
    // spared cases: arbitration stuff readback, and a passive ack error held until flag end
    if (any_err && ctx.transmitting && !arb_stuff_spare &&
        !(det.ack_err && state_reg == can_fc_pkg::ERR_PASSIVE)) begin
      tec_add8 = 1'b1;
    end
    // passive ack error only counts if another node drove dominant during our flag
    if (sample && phase_reg == can_fc_pkg::FL_FLAG && ack_pend_reg &&
        flag_cnt_reg == can_fc_pkg::FLAG_BITS - 4'h1 &&
        (dom_seen_reg || rx == can_fc_pkg::LVL_DOM)) begin
      tec_add8 = 1'b1;
    end
    if (flag_bit_err || dom_run_hit) begin
      if (flag_tx_role_reg) begin
        tec_add8 = 1'b1;
      end else begin
        rec_add8 = 1'b1;
      end
    end
    if (first_dom_err) begin
      rec_add8 = 1'b1;
    end
  end

  // receive counter: 7 bits plus overflow bit
  err_counter #(.WIDTH(can_fc_pkg::REC_W)) u_rec (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .add_one(rec_add1),
    .add_eight(rec_add8),
    .dec_one(ctx.rx_ok && !in_bus_off),
    .clear(recover),
    .count(rec_cnt)
  );

  // transmit counter: 8 bits plus overflow bit
  err_counter #(.WIDTH(can_fc_pkg::TEC_W)) u_tec (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .add_one(1'b0),
    .add_eight(tec_add8),
    .dec_one(ctx.tx_ok && !in_bus_off),
    .clear(recover),
    .count(tec_cnt)
  );

  // recessive runs seen while bus off
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idle_run_reg <= '0;
      recov_cnt_reg <= '0;
    end else if (!in_bus_off) begin
      idle_run_reg <= '0;
      recov_cnt_reg <= '0;
    end else if (ctx.bit_sample) begin
      if (rx == can_fc_pkg::LVL_DOM) begin
        idle_run_reg <= '0;
      end else if (idle_run_reg == can_fc_pkg::IDLE_RUN - 4'h1) begin
        recov_cnt_reg <= recov_cnt_reg + 8'h01;
        // standard mode counts every 11 bits of idle; enhanced needs a dominant bit between counts
        idle_run_reg <= fault_recovery_mode_select == can_fc_pkg::MODE_STANDARD ?
                        4'h0 : can_fc_pkg::IDLE_RUN;
      end else if (idle_run_reg < can_fc_pkg::IDLE_RUN) begin
        idle_run_reg <= idle_run_reg + 4'h1;
      end
    end
  end

  assign recover = in_bus_off && recov_cnt_reg == can_fc_pkg::RECOVER_COUNT;

  // fault confinement state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      can_fc_pkg::ERR_ACTIVE,
      can_fc_pkg::ERR_PASSIVE: begin
        if (tec_cnt[can_fc_pkg::TEC_W]) begin
          state_next = can_fc_pkg::ERR_BUS_OFF;
        end else if (tec_cnt > 9'(can_fc_pkg::PASSIVE_LIMIT) || rec_cnt[can_fc_pkg::REC_W]) begin
          state_next = can_fc_pkg::ERR_PASSIVE;
        end else begin
          state_next = can_fc_pkg::ERR_ACTIVE;
        end
      end
      can_fc_pkg::ERR_BUS_OFF: begin
        if (recover) begin
          state_next = can_fc_pkg::ERR_ACTIVE;
        end
      end
      default: state_next = can_fc_pkg::ERR_BUS_OFF;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= can_fc_pkg::ERR_ACTIVE;
    end else begin
      state_reg <= state_next;
    end
  end

  // driven level: flag overrides the engine, bus off stays recessive
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      can_tx_reg <= can_fc_pkg::LVL_REC;
    end else if (in_bus_off) begin
      can_tx_reg <= can_fc_pkg::LVL_REC;
    end else if (phase_reg == can_fc_pkg::FL_FLAG) begin
      can_tx_reg <= flag_dom_reg ? can_fc_pkg::LVL_DOM : can_fc_pkg::LVL_REC;
    end else if (phase_reg == can_fc_pkg::FL_IDLE) begin
      can_tx_reg <= ctx.tx_bit;
    end else begin
      can_tx_reg <= can_fc_pkg::LVL_REC;
    end
  end

  assign can_tx = can_tx_reg;
  assign can_tx_en = !in_bus_off;
  assign receive_error_count = rec_cnt;
  assign transmit_error_count = tec_cnt;
  assign error_passive = state_reg == can_fc_pkg::ERR_PASSIVE;
  assign bus_off = in_bus_off;
  assign flag_active = phase_reg == can_fc_pkg::FL_FLAG;

  // checks
  localparam int REC_LO = 1;
  localparam int REC_HI = 2;

  a_busoff_drivers: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tec_cnt[can_fc_pkg::TEC_W] && !recover) |-> ##1 !can_tx_en ##1 can_tx == can_fc_pkg::LVL_REC)
    else $error("bus off did not disable drivers");
  a_passive_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rec_cnt[can_fc_pkg::REC_W] && !tec_cnt[can_fc_pkg::TEC_W] && !in_bus_off) |=> error_passive)
    else $error("receive overflow did not give passive");
  a_active_return: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (error_passive && tec_cnt < 9'h080 && rec_cnt < 8'h80) |=> state_reg == can_fc_pkg::ERR_ACTIVE)
    else $error("passive did not return to active");
  a_recover_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(in_bus_off) && !in_bus_off) |-> (rec_cnt == '0 && tec_cnt == '0))
    else $error("counters not cleared on recovery");
  a_flag_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sample && phase_reg == can_fc_pkg::FL_IDLE && any_err && state_reg == can_fc_pkg::ERR_ACTIVE)
    ##REC_LO (phase_reg == can_fc_pkg::FL_FLAG) |-> ##REC_LO can_tx == can_fc_pkg::LVL_DOM)
    else $error("error flag not dominant");
  a_rx_increment: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rec_add1 && !rec_add8 && !recover && rec_cnt < 8'h80) |=> rec_cnt == $past(rec_cnt) + 8'h01)
    else $error("receive counter did not add one");
  a_tx_increment: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (flag_bit_err && flag_tx_role_reg && tec_cnt < 9'h0f0) |=> tec_cnt == $past(tec_cnt) + 9'h008)
    else $error("transmit counter did not add eight");
  a_arb_spare: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (arb_stuff_spare && !det.bit_err && phase_reg == can_fc_pkg::FL_IDLE) |=> tec_cnt <= $past(tec_cnt))
    else $error("arbitration stuff error counted");
  a_dec_floor: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ctx.rx_ok && rec_cnt == '0 && !rec_add1 && !rec_add8) |=> rec_cnt == '0)
    else $error("receive counter wrapped below zero");
  a_ack_error: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sample && phase_reg == can_fc_pkg::FL_IDLE && ctx.transmitting && ctx.ack_slot && rx)
    |-> ##[REC_LO:REC_HI] phase_reg == can_fc_pkg::FL_FLAG)
    else $error("missing acknowledge not flagged");

  c_passive: cover property (@(posedge clk_sys) disable iff (!rst_n) error_passive);
  c_bus_off: cover property (@(posedge clk_sys) disable iff (!rst_n) in_bus_off);
  c_recover: cover property (@(posedge clk_sys) disable iff (!rst_n) recover);
  c_long_dom: cover property (@(posedge clk_sys) disable iff (!rst_n) dom_run_hit);
endmodule

// ===== verif/can_bus_node.sv
// behavioural model of the other nodes sharing the bus with the device
`timescale 1ns/10ps
module can_bus_node (
  // device side of the bus
  input wire logic dut_tx,
  input wire logic dut_tx_en,
  // other nodes pull the bus dominant on request
  input wire logic others_dom,
  // resolved bus level
  output logic bus_level
);
  // wired-and bus; a released driver leaves the line to the pull-up, so recessive
  assign bus_level = (dut_tx_en ? dut_tx : can_fc_pkg::LVL_REC) & ~others_dom;
endmodule

// ===== verif/can_error_confinement_bench.sv
// self-checking bench for the can error confinement block
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; $display("BAD %0t got %h", $time, g); end end
module can_error_confinement_bench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic mode = 1'b0;
  logic others_dom = 1'b0;
  logic can_rx, can_tx, can_tx_en, error_passive, bus_off, flag_active, tx_seen;
  // engine idles on a recessive transmit bit, so the device does not hold the bus dominant between bits
  can_fc_pkg::bit_ctx_t ctx = '{tx_bit: 1'b1, default: 1'b0};
  can_fc_pkg::err_flags_t err_pulse, err_seen;
  logic [7:0] receive_error_count;
  logic [8:0] transmit_error_count;
  int fails = 0;
  int n_compared = 0;
  int rec_e = 0;
  int tec_e = 0;
  int k;
  // bit context presets
  localparam can_fc_pkg::bit_ctx_t C_IDLE = '{tx_bit: 1'b1, default: 1'b0};
  localparam can_fc_pkg::bit_ctx_t C_TXB = '{transmitting: 1'b1, tx_bit: 1'b1, default: 1'b0};
  localparam can_fc_pkg::bit_ctx_t C_ACK = '{transmitting: 1'b1, tx_bit: 1'b1, ack_slot: 1'b1, default: 1'b0};
  localparam can_fc_pkg::bit_ctx_t C_ARB = '{transmitting: 1'b1, tx_bit: 1'b1, arb_field: 1'b1, default: 1'b0};
  localparam can_fc_pkg::bit_ctx_t C_ARS = '{transmitting: 1'b1, tx_bit: 1'b1, arb_field: 1'b1,
    stuff_field: 1'b1, stuff_bit: 1'b1, default: 1'b0};
  localparam can_fc_pkg::bit_ctx_t C_STF = '{stuff_field: 1'b1, default: 1'b0};
  localparam can_fc_pkg::bit_ctx_t C_CRC = '{crc_check: 1'b1, crc_nonzero: 1'b1, default: 1'b0};
  localparam can_fc_pkg::bit_ctx_t C_FRM = '{fixed_bit: 1'b1, fixed_level: 1'b1, default: 1'b0};
  localparam can_fc_pkg::bit_ctx_t C_EOF = '{fixed_bit: 1'b1, fixed_level: 1'b1, last_eof_bit: 1'b1, default: 1'b0};
  localparam can_fc_pkg::bit_ctx_t C_RXOK = '{rx_ok: 1'b1, default: 1'b0};
  localparam can_fc_pkg::bit_ctx_t C_TXOK = '{tx_ok: 1'b1, default: 1'b0};

  always #25 clk_sys = ~clk_sys;

  can_bus_node node_u (.dut_tx(can_tx), .dut_tx_en(can_tx_en), .others_dom(others_dom), .bus_level(can_rx));

  can_error_confinement dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .can_rx(can_rx), .can_tx(can_tx),
    .can_tx_en(can_tx_en), .ctx(ctx), .fault_recovery_mode_select(mode), .err_pulse(err_pulse),
    .receive_error_count(receive_error_count), .transmit_error_count(transmit_error_count),
    .error_passive(error_passive), .bus_off(bus_off), .flag_active(flag_active));

  // expected confinement state from the expected counts
  function automatic logic pas_of(input int r, input int t);
    return (r > 127) || (t > 127);
  endfunction

  // bus level settles through the two input flops before the sample pulse
  task automatic send_bit(input can_fc_pkg::bit_ctx_t c, input logic dom);
    can_fc_pkg::bit_ctx_t s;
    s = c;
    s.bit_sample = 1'b1;
    @(posedge clk_sys);
    others_dom <= dom;
    repeat ($urandom_range(3, 2)) @(posedge clk_sys);
    ctx <= s;
    @(posedge clk_sys);
    ctx <= C_IDLE;
    // error pulse stands for one cycle only, take it right after the sampling edge
    #1;
    err_seen = err_pulse;
    @(posedge clk_sys);
    #1;
    tx_seen = can_tx;
  endtask

  task automatic ok_pulse(input can_fc_pkg::bit_ctx_t c);
    @(posedge clk_sys);
    ctx <= c;
    @(posedge clk_sys);
    ctx <= C_IDLE;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk_counts;
    `CHK(receive_error_count, 8'(rec_e))
    `CHK(transmit_error_count, 9'(tec_e))
  endtask

  // flag level is taken from the state held before the error
  task automatic flag6(input logic pas);
    `CHK(flag_active, 1'b1)
    for (int i = 0; i < 6; i++) begin
      send_bit(C_IDLE, 1'b0);
      if (i == 0) `CHK(tx_seen, pas ? can_fc_pkg::LVL_REC : can_fc_pkg::LVL_DOM)
    end
  endtask

  task automatic delim;
    repeat (8) send_bit(C_IDLE, 1'b0);
  endtask

  // one erroneous bit, its error frame unless bus off follows
  task automatic hit(input can_fc_pkg::bit_ctx_t c, input logic dom, input int ar, input int at,
    input can_fc_pkg::err_flags_t e);
    logic pas;
    pas = pas_of(rec_e, tec_e);
    send_bit(c, dom);
    `CHK(err_seen, e)
    rec_e += ar;
    tec_e += at;
    chk_counts();
    if (tec_e < 256) begin
      flag6(pas);
      delim();
      chk_counts();
    end
  endtask

  task automatic to_bus_off;
    while (tec_e < 256) hit(C_TXB, 1'b1, 0, 8, 5'h10);
    settle();
    `CHK(bus_off, 1'b1)
    `CHK(can_tx_en, 1'b0)
  endtask

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog, about three and a half times the expected run
  initial begin
    repeat (80000) @(posedge clk_sys);
    fails++;
    stop_test();
  end

  initial begin
    void'($urandom(98));
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    settle();
    chk_counts();
    `CHK(error_passive, 1'b0)
    `CHK(can_tx_en, 1'b1)
    ok_pulse(C_RXOK);
    ok_pulse(C_TXOK);
    chk_counts();
    $display("test reset finished");
    // receiver stuff error, then a long dominant run after the flag
    for (int i = 0; i < 5; i++) begin
      send_bit(C_STF, 1'b1);
      `CHK(err_seen, 5'h00)
    end
    hit(C_STF, 1'b1, 1, 0, 5'h08);
    hit(C_CRC, 1'b0, 1, 0, 5'h02);
    hit(C_FRM, 1'b1, 1, 0, 5'h04);
    send_bit(C_EOF, 1'b1);
    `CHK(err_seen, 5'h00)
    send_bit(C_STF, 1'b1);
    send_bit(C_STF, 1'b0);
    hit(C_FRM, 1'b1, 1, 0, 5'h04);
    rec_e = 4;
    hit(C_CRC, 1'b0, 1, 0, 5'h02);
    // dominant run: first bit after the flag, then the 14th and 8 more
    repeat (5) send_bit(C_STF, 1'b1);
    send_bit(C_STF, 1'b1);
    `CHK(err_seen, 5'h08)
    rec_e = 6;
    flag6(1'b0);
    for (int i = 1; i <= 22; i++) begin
      send_bit(C_IDLE, 1'b1);
      if (i == 1 || i == 13 || i == 14 || i == 22) begin
        rec_e = (i == 14) ? 22 : (i == 22) ? 30 : 14;
        chk_counts();
      end
    end
    delim();
    k = $urandom_range(30, 21);
    repeat (k) begin
      ok_pulse(C_RXOK);
      if (rec_e > 0) rec_e--;
      chk_counts();
    end
    $display("test receiver finished");
    hit(C_TXB, 1'b1, 0, 8, 5'h10);
    send_bit(C_ARB, 1'b1);
    `CHK(err_seen, 5'h00)
    send_bit(C_ACK, 1'b1);
    `CHK(err_seen, 5'h00)
    hit(C_ARS, 1'b1, 0, 0, 5'h08);
    $display("test transmitter finished");
    while (!pas_of(rec_e, tec_e)) hit(C_ACK, 1'b0, 0, 8, 5'h01);
    settle();
    `CHK(error_passive, 1'b1)
    hit(C_ACK, 1'b0, 0, 0, 5'h01);
    while (tec_e > 127) begin
      `CHK(error_passive, 1'b1)
      ok_pulse(C_TXOK);
      tec_e--;
    end
    settle();
    `CHK(error_passive, 1'b0)
    $display("test passive finished");
    // standard recovery; the refused error bit is recessive and counts too
    to_bus_off();
    send_bit(C_ACK, 1'b0);
    `CHK(err_seen, 5'h00)
    repeat (1406) send_bit(C_IDLE, 1'b0);
    settle();
    `CHK(bus_off, 1'b1)
    send_bit(C_IDLE, 1'b0);
    settle();
    rec_e = 0;
    tec_e = 0;
    `CHK(bus_off, 1'b0)
    chk_counts();
    $display("test standard recovery finished");
    // enhanced recovery; a long recessive run counts only once
    @(posedge clk_sys);
    mode <= can_fc_pkg::MODE_ENHANCED;
    to_bus_off();
    for (int m = 0; m < 127; m++) begin
      send_bit(C_IDLE, 1'b1);
      repeat (m == 0 ? 30 : 11) send_bit(C_IDLE, 1'b0);
    end
    settle();
    `CHK(bus_off, 1'b1)
    send_bit(C_IDLE, 1'b1);
    repeat (11) send_bit(C_IDLE, 1'b0);
    settle();
    rec_e = 0;
    tec_e = 0;
    `CHK(bus_off, 1'b0)
    chk_counts();
    $display("test enhanced recovery finished");
    stop_test();
  end
endmodule
